// >>> rtl/mpio_top.sv
// Multi-port I/O block: ports 0, 1, 4 and 8 to 12 with direction and segment select.
// Assumes a CPU-side byte write strobe, reads by select alone, and pads resolved outside.
//
// Behaviour
// - Port 0 has five bidirectional pins, direction set per pin.
// - Port 1 has four input-only pins that never drive.
// - Port 4 has eight bidirectional pins; upper two share sound outputs.
// - Ports 8 to 12 pins act as port or segment output per bit.
// - Segment selection is per bit; neighbours may differ.
// - Direction registers exist for ports 0, 4 and 8 to 12.
// - Segment select registers exist only for ports 8 to 12.
// - Reset sets all direction registers to all ones, inputs.
// - Reset clears all segment select registers.
// - Port writes always update the latch, which holds until rewritten.
// - Read returns pin level for inputs, latch for outputs, latch untouched.
`timescale 1ns/100ps
`include "mpio_params.svh"
module mpio_top (
	// Clock and reset
	input  wire logic                                  clk_i,
	input  wire logic                                  reset_n_i,
	// CPU register access
	input  wire logic [4:0]                            reg_sel_i,
	input  wire logic                                  reg_wr_i,
	input  wire logic [7:0]                            reg_wdata_i,
	output logic      [7:0]                            reg_rdata_o,
	// Bidirectional ports 0, 4, 8 to 12
	input  wire logic [`MPIO_NUM_PORTS-1:0][7:0]       pad_i,
	output logic      [`MPIO_NUM_PORTS-1:0][7:0]       pad_o,
	output logic      [`MPIO_NUM_PORTS-1:0][7:0]       pad_oe_n_o,
	output logic      [`MPIO_NUM_PORTS-1:0][7:0]       pad_level_o,
	// Input-only port 1
	input  wire logic [`MPIO_IN_ONLY_W-1:0]            analog_inputs_i,
	output logic      [`MPIO_IN_ONLY_W-1:0]            analog_level_o,
	// Segment data from the LCD driver, ports 8 to 12
	input  wire logic [`MPIO_NUM_SEG-1:0][7:0]         seg_data_i,
	// Sound generator on port 4
	input  wire logic                                  sound_en_i,
	input  wire logic                                  sound_out_inverted_i,
	input  wire logic                                  sound_out_main_i
);

	mpio_sync_if #(.W(`MPIO_SYNC_W)) u_sif ();

	logic [`MPIO_NUM_PORTS-1:0][7:0] lvl;
	logic [`MPIO_NUM_PORTS-1:0][7:0] seg_all;
	logic [`MPIO_NUM_PORTS-1:0][7:0] alt_en_all;
	logic [`MPIO_NUM_PORTS-1:0][7:0] alt_val_all;
	logic [`MPIO_NUM_PORTS-1:0][7:0] rd_port;
	logic [`MPIO_NUM_PORTS-1:0][7:0] rd_dir;
	logic [`MPIO_NUM_PORTS-1:0][7:0] rd_seg;
	logic [`MPIO_IN_ONLY_W-1:0]      p1_lvl;
	mpio_pkg::mpio_grp_t             grp;
	logic [2:0]                      idx;
	logic [7:0]                      rd_ff;
	logic [7:0]                      nxt_rd;

	assign u_sif.raw = {analog_inputs_i, pad_i};
	assign lvl       = u_sif.level[`MPIO_NUM_PORTS*8-1:0];
	assign p1_lvl    = u_sif.level[`MPIO_SYNC_W-1:`MPIO_NUM_PORTS*8];

	mpio_sync #(.W(`MPIO_SYNC_W)) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.s         (u_sif.flt)
	);

	assign grp = mpio_pkg::mpio_grp_t'(reg_sel_i[4:3]);
	assign idx = reg_sel_i[2:0];

	// Segment data lands on slots 2..6, sound on slot 1
	always_comb begin
		seg_all     = {seg_data_i, 16'h0000};
		alt_en_all  = '0;
		alt_val_all = '0;
		if (sound_en_i) begin
			alt_en_all[`MPIO_IDX_P4] = `MPIO_SND_EN_MASK;
		end
		alt_val_all[`MPIO_IDX_P4] = {sound_out_main_i, sound_out_inverted_i, 6'h00};
	end

	for (genvar k = 0; k < `MPIO_NUM_PORTS; k++) begin : g_port
		localparam logic [7:0] MASK    = (k == 0) ? `MPIO_P0_MASK : `MPIO_FULL_MASK;
		localparam bit         HAS_SEG = (k >= `MPIO_FIRST_SEG);

		logic [7:0] lat_ff;
		logic [7:0] dir_ff;
		logic [7:0] seg_ff;
		logic [7:0] out_ff;
		logic [7:0] oe_n_ff;
		logic [7:0] nxt_lat;
		logic [7:0] nxt_dir;
		logic [7:0] nxt_seg;
		logic [7:0] nxt_out;
		logic [7:0] nxt_oe_n;
		logic       hit;

		assign hit = reg_wr_i && (idx == 3'(k));

		always_comb begin
			nxt_lat = lat_ff;
			nxt_dir = dir_ff;
			nxt_seg = seg_ff;
			if (hit) begin
				case (grp)
					mpio_pkg::MPIO_GRP_DATA: begin
						nxt_lat = reg_wdata_i;
					end
					mpio_pkg::MPIO_GRP_DIR: begin
						// Absent pins stay inputs
						nxt_dir = reg_wdata_i | ~MASK;
					end
					mpio_pkg::MPIO_GRP_SEG: begin
						if (HAS_SEG) begin
							nxt_seg = reg_wdata_i;
						end
					end
					default: begin
						nxt_lat = lat_ff;
					end
				endcase
			end
			// Segment wins, then alternate, then latch
			nxt_out = MASK & ((seg_ff & seg_all[k])
				| (~seg_ff & alt_en_all[k] & alt_val_all[k])
				| (~seg_ff & ~alt_en_all[k] & lat_ff));
			nxt_oe_n = ~MASK | (dir_ff & ~seg_ff);
		end

		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				lat_ff  <= `MPIO_LAT_RST;
				dir_ff  <= `MPIO_DIR_RST;
				seg_ff  <= `MPIO_SEG_RST;
				out_ff  <= `MPIO_OUT_RST;
				oe_n_ff <= `MPIO_DIR_RST;
			end else begin
				lat_ff  <= nxt_lat;
				dir_ff  <= nxt_dir;
				seg_ff  <= nxt_seg;
				out_ff  <= nxt_out;
				oe_n_ff <= nxt_oe_n;
			end
		end

		assign rd_port[k]     = MASK & ((dir_ff & lvl[k]) | (~dir_ff & lat_ff));
		assign rd_dir[k]      = dir_ff;
		assign rd_seg[k]      = seg_ff;
		assign pad_o[k]       = out_ff;
		assign pad_oe_n_o[k]  = oe_n_ff;
		assign pad_level_o[k] = lvl[k];
	end

	// Port 1 has no latch, no direction, no driver
	assign analog_level_o = p1_lvl;

	// Read data mux, unmapped selects read zero
	always_comb begin
		nxt_rd = `MPIO_RD_RST;
		if (idx == `MPIO_IDX_P1) begin
			if (grp == mpio_pkg::MPIO_GRP_DATA) begin
				nxt_rd = {4'h0, p1_lvl};
			end
		end else if (grp == mpio_pkg::MPIO_GRP_DATA) begin
			nxt_rd = rd_port[idx];
		end else if (grp == mpio_pkg::MPIO_GRP_DIR) begin
			nxt_rd = rd_dir[idx];
		end else if (grp == mpio_pkg::MPIO_GRP_SEG) begin
			nxt_rd = rd_seg[idx];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_ff <= `MPIO_RD_RST;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	assign reg_rdata_o = rd_ff;

endmodule // mpio_top

// >>> rtl/mpio_params.svh
// Constants for the multi-port I/O block: port indexes, masks, reset values.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef MPIO_PARAMS_SVH
`define MPIO_PARAMS_SVH

// Port slots held by the register array
`define MPIO_NUM_PORTS   7
`define MPIO_NUM_SEG     5
`define MPIO_FIRST_SEG   2
`define MPIO_PORT_W      8
`define MPIO_IN_ONLY_W   4
`define MPIO_SYNC_W      60

// Register select, index field
`define MPIO_IDX_P0      3'h0
`define MPIO_IDX_P4      3'h1
`define MPIO_IDX_P8      3'h2
`define MPIO_IDX_P9      3'h3
`define MPIO_IDX_P10     3'h4
`define MPIO_IDX_P11     3'h5
`define MPIO_IDX_P12     3'h6
`define MPIO_IDX_P1      3'h7

// Pins present per port
`define MPIO_P0_MASK     8'hC7
`define MPIO_FULL_MASK   8'hFF

// Reset values
`define MPIO_DIR_RST     8'hFF
`define MPIO_SEG_RST     8'h00
`define MPIO_LAT_RST     8'h00
`define MPIO_OUT_RST     8'h00
`define MPIO_RD_RST      8'h00

// Sound outputs shared on port 4
`define MPIO_SND_EN_MASK 8'hC0

`endif

// >>> rtl/mpio_pkg.sv
// Types for the multi-port I/O block.
// Assumes nothing of its surroundings.
package mpio_pkg;

	typedef logic [7:0] mpio_byte_t;

	typedef enum logic [1:0] {
		MPIO_GRP_DATA,
		MPIO_GRP_DIR,
		MPIO_GRP_SEG,
		MPIO_GRP_NONE
	} mpio_grp_t;

endpackage

// >>> rtl/mpio_sync_if.sv
// Carrier between the port logic and the pin-input filter.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface mpio_sync_if #(
	parameter int W = 60
);
	logic [W-1:0] raw;
	logic [W-1:0] level;

	modport src (output raw, input level);
	modport flt (input raw, output level);
endinterface

// >>> rtl/mpio_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes raw inputs asynchronous to clk_i.
`timescale 1ns/100ps
module mpio_sync #(
	parameter int W = 60
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Filter side of the carrier
	mpio_sync_if.flt  s
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] lvl_ff;
	logic [W-1:0] nxt_lvl;

	// Level moves only once stages two and three agree
	always_comb begin
		nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			lvl_ff <= '0;
		end else begin
			s1_ff  <= s.raw;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign s.level = lvl_ff;

endmodule // mpio_sync

// >>> sim/mpio_pad_model.sv
// Pin model: each pad follows the block while driven, the board otherwise.
// Assumes active-low output enables, one per pin.
`timescale 1ns/100ps
module mpio_pad_model (
	// Block side
	input  wire logic [6:0][7:0] pad_o,
	input  wire logic [6:0][7:0] pad_oe_n_o,
	// Board side
	input  wire logic [6:0][7:0] ext_i,
	output logic      [6:0][7:0] pad_i
);
	assign pad_i = (~pad_oe_n_o & pad_o) | (pad_oe_n_o & ext_i);
endmodule // mpio_pad_model

// >>> sim/mpio_chk.sv
// Port checker for the multi-port I/O block.
// Assumes the select encoding and the latencies of the block's hand-over.
`timescale 1ns/100ps
module mpio_chk (
	input wire logic            clk_i,
	input wire logic            reset_n_i,
	input wire logic [4:0]      reg_sel_i,
	input wire logic            reg_wr_i,
	input wire logic [7:0]      reg_wdata_i,
	input wire logic [7:0]      reg_rdata_o,
	input wire logic [6:0][7:0] pad_o,
	input wire logic [6:0][7:0] pad_oe_n_o,
	input wire logic [3:0]      analog_inputs_i,
	input wire logic [3:0]      analog_level_o,
	input wire logic            sound_en_i,
	input wire logic            sound_out_inverted_i,
	input wire logic            sound_out_main_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	rst_vals_a: assert property ($rose(reset_n_i) |-> &pad_oe_n_o && pad_o == '0)
		else $error("pins not released after reset");
	p0_gap_a: assert property (pad_oe_n_o[0][5:3] == 3'h7 && pad_o[0][5:3] == 3'h0)
		else $error("absent port 0 pin driven");
	dir_drive_a: assert property (reg_wr_i && reg_sel_i == 5'h09 |-> ##2
		pad_oe_n_o[1] == $past(reg_wdata_i, 2)) else $error("drive differs from direction");
	sound_mux_a: assert property (sound_en_i |=>
		pad_o[1][7:6] == $past({sound_out_main_i, sound_out_inverted_i})) else $error("sound");
	seg_drive_a: assert property (reg_wr_i && reg_sel_i == 5'h12 |-> ##2
		(pad_oe_n_o[2] & $past(reg_wdata_i, 2)) == 8'h00) else $error("segment pin off");
	dir_rb_a: assert property (reg_wr_i && reg_sel_i == 5'h09 ##1 reg_sel_i == 5'h09 |=>
		reg_rdata_o == $past(reg_wdata_i, 2)) else $error("direction readback");
	rd_latch_a: assert property (!$past(reg_wr_i) && reg_wr_i && reg_sel_i == 5'h01 &&
		pad_oe_n_o[1] == 8'h00 ##1 reg_sel_i == 5'h01 |=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("output latch readback");
	ana_level_a: assert property ($stable(analog_inputs_i)[*6] |->
		analog_level_o == analog_inputs_i) else $error("input-only level");
	cover property (reg_wr_i && reg_sel_i == 5'h12);
	cover property (sound_en_i && pad_oe_n_o[1] == 8'h00);
	cover property ($rose(reset_n_i));
endmodule // mpio_chk
bind mpio_top mpio_chk i_mpio_chk (.clk_i, .reset_n_i, .reg_sel_i, .reg_wr_i, .reg_wdata_i,
	.reg_rdata_o, .pad_o, .pad_oe_n_o, .analog_inputs_i, .analog_level_o, .sound_en_i,
	.sound_out_inverted_i, .sound_out_main_i);

// >>> sim/tb_top.sv
// Self-checking bench for the multi-port I/O block.
// Assumes the pad model and the bound checker in sim/.
`timescale 1ns/100ps
module tb_top;
	logic            clk_i, reset_n_i, reg_wr_i, sound_en_i;
	logic            sound_out_inverted_i, sound_out_main_i;
	logic [4:0]      reg_sel_i;
	logic [7:0]      reg_wdata_i, reg_rdata_o, d, l, m, rv;
	logic [6:0][7:0] pad_i, pad_o, pad_oe_n_o, pad_level_o, ext;
	logic [3:0]      analog_inputs_i, analog_level_o;
	logic [4:0][7:0] seg_data_i;
	int              failures, n_checks, seed, k, i;
	mpio_top i_mpio_top (.clk_i, .reset_n_i, .reg_sel_i, .reg_wr_i, .reg_wdata_i,
		.reg_rdata_o, .pad_i, .pad_o, .pad_oe_n_o, .pad_level_o, .analog_inputs_i,
		.analog_level_o, .seg_data_i, .sound_en_i, .sound_out_inverted_i, .sound_out_main_i);
	mpio_pad_model i_mpio_pad_model (.pad_o, .pad_oe_n_o, .ext_i(ext), .pad_i);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] s, input logic [7:0] v);
		@(negedge clk_i) {reg_sel_i, reg_wdata_i, reg_wr_i} = {s, v, 1'b1};
		@(negedge clk_i) reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [4:0] s);
		@(negedge clk_i) reg_sel_i = s;
		@(negedge clk_i) rv = reg_rdata_o;
	endtask
	function automatic logic [7:0] exp_rd(input logic [7:0] dr, la, pin, mk);
		return ((dr & pin) | (~dr & la)) & mk;
	endfunction
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	initial begin
		seed = 77;
		{reset_n_i, reg_wr_i, sound_en_i, sound_out_inverted_i, sound_out_main_i} = 5'h00;
		{reg_sel_i, reg_wdata_i, analog_inputs_i, ext, seg_data_i} = '0;
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		for (k = 0; k < 7; k++) begin
			chk(pad_oe_n_o[k], 8'hFF);
			rd({2'd1, 3'(k)});
			chk(rv, 8'hFF);
			rd({2'd2, 3'(k)});
			chk(rv, 8'h00);
		end
		$display("reset test done");
		for (k = 0; k < 30; k++) begin
			i = {$random(seed)} % 7;
			d = k < 2 ? {8{k[0]}} : 8'($random(seed));
			l = 8'($random(seed));
			ext[i] = 8'($random(seed));
			m = i == 0 ? 8'hC7 : 8'hFF;
			wr({2'd1, 3'(i)}, d);
			wr({2'd0, 3'(i)}, l);
			repeat (6) @(negedge clk_i);
			chk(pad_oe_n_o[i], d | ~m);
			chk(pad_o[i], l & m);
			chk(pad_level_o[i], ((d | ~m) & ext[i]) | (~(d | ~m) & l & m));
			rd({2'd0, 3'(i)});
			chk(rv, exp_rd(d, l, ext[i], m));
			rd({2'd1, 3'(i)});
			chk(rv, d | ~m);
		end
		$display("random port test done");
		wr(5'h18, 8'h5A);
		rd(5'h18);
		chk(rv, 8'h00);
		wr(5'h11, 8'hFF);
		rd(5'h11);
		chk(rv, 8'h00);
		analog_inputs_i = 4'($random(seed));
		repeat (6) @(negedge clk_i);
		rd(5'h07);
		chk(rv, {4'h0, analog_inputs_i});
		for (i = 0; i < 5; i++) begin
			seg_data_i[i] = 8'($random(seed));
			wr({2'd1, 3'(i + 2)}, 8'hFF);
			wr({2'd2, 3'(i + 2)}, 8'hA5);
			repeat (3) @(negedge clk_i);
			chk(pad_oe_n_o[i + 2], 8'h5A);
			chk(pad_o[i + 2] & 8'hA5, seg_data_i[i] & 8'hA5);
			rd({2'd2, 3'(i + 2)});
			chk(rv, 8'hA5);
		end
		$display("segment test done");
		wr(5'h09, 8'h00);
		wr(5'h01, 8'h3C);
		{sound_en_i, sound_out_main_i, sound_out_inverted_i} = 3'h6;
		rd(5'h01);
		chk(rv, 8'h3C);
		repeat (2) @(negedge clk_i);
		chk(pad_o[1], 8'hBC);
		chk(pad_oe_n_o[1], 8'h00);
		$display("sound test done");
		give_verdict();
	end
endmodule // tb_top
